// ### src/toc_pkg.sv
// constants for the timer output compare unit
package toc_pkg;
	localparam int CNT_W = 8;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [7:0] CNT_RESET = 8'h00;
	localparam logic [7:0] CMP_RESET = 8'h00;
	localparam logic OUT_RESET = 1'b0;
	localparam logic [2:0] WGM_NORMAL = 3'h0;
	localparam logic [2:0] WGM_PC_MAX = 3'h1;
	localparam logic [2:0] WGM_CTC = 3'h2;
	localparam logic [2:0] WGM_FAST_MAX = 3'h3;
	localparam logic [2:0] WGM_PC_CMP = 3'h5;
	localparam logic [2:0] WGM_FAST_CMP = 3'h7;
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR = 2'h2;
	localparam logic [1:0] ACT_SET = 2'h3;
	localparam logic [2:0] CS_STOPPED = 3'h0;
	localparam int CS_DIV_W = 10;
endpackage : toc_pkg

// ### src/toc_compare_unit.sv
// one compare channel: buffer, comparator, flag, output state and pin mux
`timescale 1ns/1ps
module toc_compare_unit (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// timer context
	input wire logic tick,
	input wire logic [7:0] count,
	input wire logic block,
	input wire logic pwmMode,
	input wire logic dualSlope,
	input wire logic downCount,
	input wire logic atTop,
	input wire logic atBottom,
	// cpu side
	input wire logic cmpWr,
	input wire logic [7:0] cmpWrData,
	input wire logic [1:0] outputActionField,
	input wire logic forceCompareStrobe,
	input wire logic flagClrWr,
	input wire logic intEnable,
	input wire logic intAck,
	// results
	output logic [7:0] compareActive,
	output logic [7:0] compareBuf,
	output logic compareFlag,
	output logic outputState,
	output logic intReq,
	// pin
	input wire logic portData,
	input wire logic portDir,
	output logic pinOut,
	output logic pinOe
);
	logic matchNow;
	logic matchPend_q;
	logic applyEv;
	logic nextOut;

	////////////////////////////////////////////////////////////
	// write steering
	always_ff @(posedge mclk) begin
		if (rst) begin
			compareBuf <= toc_pkg::CMP_RESET;
		end else if (cmpWr) begin
			compareBuf <= cmpWrData;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			compareActive <= toc_pkg::CMP_RESET;
		end else if (cmpWr && !pwmMode) begin
			compareActive <= cmpWrData;
		end else if (pwmMode && tick && (dualSlope ? atTop : atBottom)) begin
			compareActive <= compareBuf;
		end
	end

	////////////////////////////////////////////////////////////
	// equality compare, blocked after counter write
	assign matchNow = (count == compareActive) && !block;

	always_ff @(posedge mclk) begin
		if (rst) begin
			matchPend_q <= 1'b0;
		end else if (tick) begin
			matchPend_q <= matchNow;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			compareFlag <= 1'b0;
		end else if (tick && matchPend_q) begin
			compareFlag <= 1'b1;
		end else if (flagClrWr || (intAck && intEnable)) begin
			compareFlag <= 1'b0;
		end
	end

	assign intReq = compareFlag && intEnable;

	////////////////////////////////////////////////////////////
	// force acts like match, non-pwm only
	assign applyEv = (tick && matchPend_q) || (forceCompareStrobe && !pwmMode);

	always_comb begin
		nextOut = outputState;
		unique case (outputActionField)
			toc_pkg::ACT_NONE: nextOut = outputState;
			toc_pkg::ACT_TOGGLE: nextOut = pwmMode ? outputState : ~outputState;
			toc_pkg::ACT_CLEAR: nextOut = pwmMode && dualSlope && downCount;
			toc_pkg::ACT_SET: nextOut = !(pwmMode && dualSlope && downCount);
		endcase
	end

	// state kept across modes, action live
	always_ff @(posedge mclk) begin
		if (rst) begin
			outputState <= toc_pkg::OUT_RESET;
		end else if (applyEv) begin
			outputState <= nextOut;
		end else if (pwmMode && !dualSlope && tick && atTop && outputActionField[1]) begin
			// fast pwm: restore level as the count wraps to bottom
			outputState <= ~outputActionField[0];
		end
	end

	assign pinOut = (outputActionField != toc_pkg::ACT_NONE) ? outputState : portData;
	assign pinOe = portDir;
endmodule : toc_compare_unit

// ### src/toc_timer8.sv
// 8-bit timer with two output compare channels and normal, CTC, fast pwm and phase-correct pwm counting
`timescale 1ns/1ps
// Functional notes
// - compare counter with both values continuously
// - flag sets on tick after match
// - enabled flag requests interrupt, service clears
// - writing one clears flag
// - double buffer only in pwm modes
// - buffer transfers at top or bottom
// - cpu writes buffer or active register
// - force strobe updates output in non-pwm modes only, no flag
// - counter write blocks next tick matches
// - output state kept across mode change
// - action field not double buffered
// - reset clears output state
// - nonzero action overrides port data
// - override independent of waveform mode
// - action zero leaves output unchanged
// - mode sets counting, action sets output
// - normal mode counts up, wraps
// - overflow flag set when counter zero
// - overflow service clears flag
// - counter writable at any time
// - counter write beats counting
// - bottom is zero, max is ff
// - clock select zero stops ticks
module toc_timer8 #(
	parameter int DIV_W = toc_pkg::CS_DIV_W
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// configuration
	input wire logic [2:0] waveformModeSel,
	input wire logic [2:0] clockSourceSel,
	input wire logic extTick,
	// counter access
	input wire logic counterWr,
	input wire logic [7:0] counterWrData,
	output logic [7:0] counterValue,
	// compare access
	input wire logic cmpWrA,
	input wire logic cmpWrB,
	input wire logic [7:0] cmpWrData,
	output logic [7:0] compareValueA,
	output logic [7:0] compareValueB,
	input wire logic [1:0] outputActionFieldA,
	input wire logic [1:0] outputActionFieldB,
	input wire logic forceCompareStrobeA,
	input wire logic forceCompareStrobeB,
	// flags and interrupts
	input wire logic flagClrA,
	input wire logic flagClrB,
	input wire logic flagClrOvf,
	input wire logic intEnA,
	input wire logic intEnB,
	input wire logic intEnOvf,
	input wire logic intAckA,
	input wire logic intAckB,
	input wire logic intAckOvf,
	output logic compareFlagA,
	output logic compareFlagB,
	output logic overflowFlag,
	output logic intReqA,
	output logic intReqB,
	output logic intReqOvf,
	output logic outputStateA,
	output logic outputStateB,
	// pins
	input wire logic portDataA,
	input wire logic portDataB,
	input wire logic portDirA,
	input wire logic portDirB,
	output logic pinOutA,
	output logic pinOutB,
	output logic pinOeA,
	output logic pinOeB
);
	logic [DIV_W-1:0] div_q;
	logic tick;
	logic block_q;
	logic down_q;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic [7:0] top;
	logic pwmMode;
	logic dualSlope;
	logic atTop;
	logic atBottom;
	logic ovf_q;
	logic [7:0] actA;
	logic [7:0] actB;
	logic [7:0] bufA;
	logic [7:0] bufB;
	logic flA;
	logic flB;
	logic osA;
	logic osB;
	logic irA;
	logic irB;
	logic poA;
	logic poB;
	logic oeA;
	logic oeB;

	function automatic logic isPwm(input logic [2:0] m);
		return (m == toc_pkg::WGM_PC_MAX) || (m == toc_pkg::WGM_FAST_MAX) ||
			(m == toc_pkg::WGM_PC_CMP) || (m == toc_pkg::WGM_FAST_CMP);
	endfunction : isPwm

	////////////////////////////////////////////////////////////
	// free prescaler; select picks a tap of 1, 8, 64, 256 or 1024 clocks
	always_ff @(posedge mclk) begin
		if (rst) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	always_comb begin
		unique case (clockSourceSel)
			toc_pkg::CS_STOPPED: tick = 1'b0;
			3'h1: tick = 1'b1;
			3'h2: tick = (div_q[2:0] == 3'h7);
			3'h3: tick = (div_q[5:0] == 6'h3F);
			3'h4: tick = (div_q[7:0] == 8'hFF);
			3'h5: tick = (div_q == '1);
			default: tick = extTick;
		endcase
	end

	////////////////////////////////////////////////////////////
	assign pwmMode = isPwm(waveformModeSel);
	assign dualSlope = pwmMode && !waveformModeSel[1];
	assign top = (waveformModeSel == toc_pkg::WGM_CTC || waveformModeSel == toc_pkg::WGM_PC_CMP ||
		waveformModeSel == toc_pkg::WGM_FAST_CMP) ? actA : toc_pkg::CNT_MAX;
	assign atTop = (cnt_q == top);
	assign atBottom = (cnt_q == toc_pkg::CNT_BOTTOM);

	always_comb begin
		cnt_d = cnt_q;
		if (tick) begin
			if (dualSlope) begin
				cnt_d = (down_q && !atBottom) || (!down_q && atTop) ? cnt_q - 8'h01 : cnt_q + 8'h01;
			end else if (waveformModeSel != toc_pkg::WGM_NORMAL && atTop) begin
				cnt_d = toc_pkg::CNT_BOTTOM;
			end else begin
				cnt_d = cnt_q + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q <= toc_pkg::CNT_RESET;
		end else if (counterWr) begin
			cnt_q <= counterWrData;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			down_q <= 1'b0;
		end else if (!dualSlope) begin
			down_q <= 1'b0;
		end else if (tick && atTop) begin
			down_q <= 1'b1;
		end else if (tick && atBottom) begin
			down_q <= 1'b0;
		end
	end

	// block held until next tick, even stopped
	always_ff @(posedge mclk) begin
		if (rst) begin
			block_q <= 1'b0;
		end else if (counterWr) begin
			block_q <= 1'b1;
		end else if (tick) begin
			block_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////
	// overflow flag, set beats clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			ovf_q <= 1'b0;
		end else if (tick && !counterWr && cnt_d == toc_pkg::CNT_BOTTOM &&
			cnt_q != toc_pkg::CNT_BOTTOM && !dualSlope) begin
			ovf_q <= 1'b1;
		end else if (tick && dualSlope && down_q && cnt_d == toc_pkg::CNT_BOTTOM) begin
			ovf_q <= 1'b1;
		end else if (flagClrOvf || (intAckOvf && intEnOvf)) begin
			ovf_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////
	// both channels on the shared tick
	toc_compare_unit u_chA (
		// clock and reset
		.mclk(mclk),
		.rst(rst),
		// timer context
		.tick(tick),
		.count(cnt_q),
		.block(block_q),
		.pwmMode(pwmMode),
		.dualSlope(dualSlope),
		.downCount(down_q),
		.atTop(atTop),
		.atBottom(atBottom),
		// cpu side
		.cmpWr(cmpWrA),
		.cmpWrData(cmpWrData),
		.outputActionField(outputActionFieldA),
		.forceCompareStrobe(forceCompareStrobeA),
		.flagClrWr(flagClrA),
		.intEnable(intEnA),
		.intAck(intAckA),
		// results
		.compareActive(actA),
		.compareBuf(bufA),
		.compareFlag(flA),
		.outputState(osA),
		.intReq(irA),
		// pin
		.portData(portDataA),
		.portDir(portDirA),
		.pinOut(poA),
		.pinOe(oeA)
	);

	toc_compare_unit u_chB (
		// clock and reset
		.mclk(mclk),
		.rst(rst),
		// timer context
		.tick(tick),
		.count(cnt_q),
		.block(block_q),
		.pwmMode(pwmMode),
		.dualSlope(dualSlope),
		.downCount(down_q),
		.atTop(atTop),
		.atBottom(atBottom),
		// cpu side
		.cmpWr(cmpWrB),
		.cmpWrData(cmpWrData),
		.outputActionField(outputActionFieldB),
		.forceCompareStrobe(forceCompareStrobeB),
		.flagClrWr(flagClrB),
		.intEnable(intEnB),
		.intAck(intAckB),
		// results
		.compareActive(actB),
		.compareBuf(bufB),
		.compareFlag(flB),
		.outputState(osB),
		.intReq(irB),
		// pin
		.portData(portDataB),
		.portDir(portDirB),
		.pinOut(poB),
		.pinOe(oeB)
	);

	////////////////////////////////////////////////////////////
	// registered outputs; costs one cycle of pin latency
	// counter and compare readback
	always_ff @(posedge mclk) begin
		if (rst) begin
			counterValue <= toc_pkg::CNT_RESET;
			compareValueA <= toc_pkg::CMP_RESET;
			compareValueB <= toc_pkg::CMP_RESET;
		end else begin
			counterValue <= cnt_q;
			// cpu reads back the register it writes
			compareValueA <= pwmMode ? bufA : actA;
			compareValueB <= pwmMode ? bufB : actB;
		end
	end

	// flags
	always_ff @(posedge mclk) begin
		if (rst) begin
			compareFlagA <= 1'b0;
			compareFlagB <= 1'b0;
			overflowFlag <= 1'b0;
		end else begin
			compareFlagA <= flA;
			compareFlagB <= flB;
			overflowFlag <= ovf_q;
		end
	end

	// interrupt requests
	always_ff @(posedge mclk) begin
		if (rst) begin
			intReqA <= 1'b0;
			intReqB <= 1'b0;
			intReqOvf <= 1'b0;
		end else begin
			intReqA <= irA;
			intReqB <= irB;
			intReqOvf <= ovf_q && intEnOvf;
		end
	end

	// output states
	always_ff @(posedge mclk) begin
		if (rst) begin
			outputStateA <= toc_pkg::OUT_RESET;
			outputStateB <= toc_pkg::OUT_RESET;
		end else begin
			outputStateA <= osA;
			outputStateB <= osB;
		end
	end

	// pin drive
	always_ff @(posedge mclk) begin
		if (rst) begin
			pinOutA <= 1'b0;
			pinOutB <= 1'b0;
			pinOeA <= 1'b0;
			pinOeB <= 1'b0;
		end else begin
			pinOutA <= poA;
			pinOutB <= poB;
			pinOeA <= oeA;
			pinOeB <= oeB;
		end
	end
endmodule : toc_timer8

// ### tb/toc_pin_model.sv
// port pad model with a weak pull-up
`timescale 1ns/1ps
module toc_pin_model (
	// pad
	input wire logic pinOut,
	input wire logic pinOe,
	output logic pinLevel
);
	assign pinLevel = pinOe ? pinOut : 1'b1;
endmodule : toc_pin_model

// ### tb/toc_timer8_assertions.sv
// port-level checks for the timer compare block
`timescale 1ns/1ps
module toc_timer8_assertions (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// watched ports
	input wire logic [2:0] waveformModeSel,
	input wire logic [2:0] clockSourceSel,
	input wire logic counterWr,
	input wire logic [7:0] counterValue,
	input wire logic [7:0] compareValueA,
	input wire logic [1:0] outputActionFieldA,
	input wire logic forceCompareStrobeA,
	input wire logic flagClrA,
	input wire logic intAckA,
	input wire logic intEnA,
	input wire logic compareFlagA,
	input wire logic overflowFlag,
	input wire logic outputStateA,
	input wire logic pinOutA,
	input wire logic portDirA,
	input wire logic pinOeA
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	logic [3:0] hit_q;
	// port view lags the comparator, so keep a short history
	always_ff @(posedge mclk) begin
		hit_q <= {hit_q[2:0], counterValue == compareValueA};
	end
	////////////////////
	sequence s_run;
		waveformModeSel == 3'h0 && clockSourceSel == 3'h1 && !counterWr;
	endsequence
	property p_flagA; $rose(compareFlagA) |-> |hit_q; endproperty
	a_flagA: assert property (p_flagA) else $error("flag without match");
	property p_clrA; flagClrA ##2 !(|hit_q) |-> !compareFlagA; endproperty
	a_clrA: assert property (p_clrA) else $error("flag not cleared");
	property p_ackA; intAckA && intEnA ##2 !(|hit_q) |-> !compareFlagA; endproperty
	a_ackA: assert property (p_ackA) else $error("service kept flag");
	property p_forceA;
		forceCompareStrobeA && waveformModeSel == 3'h0 && outputActionFieldA == 2'h3 |-> ##2 outputStateA;
	endproperty
	a_forceA: assert property (p_forceA) else $error("force did not set");
	property p_pinA;
		(outputActionFieldA != 2'h0 && $stable(outputStateA))[*3] |-> pinOutA == outputStateA;
	endproperty
	a_pinA: assert property (p_pinA) else $error("pin not overridden");
	property p_oeA; $stable(portDirA)[*3] |-> pinOeA == portDirA; endproperty
	a_oeA: assert property (p_oeA) else $error("pin direction wrong");
	property p_count; s_run[*5] |-> counterValue == $past(counterValue) + 8'h01; endproperty
	a_count: assert property (p_count) else $error("count not up by one");
	property p_stop; (clockSourceSel == 3'h0 && !counterWr)[*4] |-> $stable(counterValue); endproperty
	a_stop: assert property (p_stop) else $error("stopped counter moved");
	property p_ovf; $rose(overflowFlag) |-> counterValue == 8'h00; endproperty
	a_ovf: assert property (p_ovf) else $error("overflow off zero");
	property p_rst; $fell(rst) |-> !outputStateA; endproperty
	a_rst: assert property (p_rst) else $error("state not reset");
endmodule : toc_timer8_assertions

bind toc_timer8 toc_timer8_assertions u_chk (.*);

// ### tb/testbench.sv
// self-checking bench for the timer compare block
`timescale 1ns/1ps
module testbench;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] modeSel = 3'h0;
	logic [2:0] clkSel = 3'h0;
	logic [10:0] pls = 11'h000;
	logic [7:0] wrD = 8'h00;
	logic [2:0] intEn = 3'h0;
	logic [1:0] actA = 2'h0;
	logic [1:0] actB = 2'h0;
	logic [1:0] pData = 2'h0;
	logic [1:0] pDir = 2'h0;
	logic [7:0] cnt, cmpA, cmpB, rnd, v;
	logic [2:0] flg, irq;
	logic [1:0] st, pOut, pOe;
	logic lvlA, e;
	logic [1:0] acts [5] = '{toc_pkg::ACT_SET, toc_pkg::ACT_TOGGLE, toc_pkg::ACT_NONE,
		toc_pkg::ACT_TOGGLE, toc_pkg::ACT_CLEAR};
	int n_mismatch = 0;
	int check_count = 0;
	always #25 mclk = ~mclk;
	toc_timer8 DUT (.mclk(mclk), .rst(rst), .waveformModeSel(modeSel), .clockSourceSel(clkSel),
		.extTick(1'b0), .counterWr(pls[0]), .counterWrData(wrD), .counterValue(cnt), .cmpWrA(pls[1]),
		.cmpWrB(pls[2]), .cmpWrData(wrD), .compareValueA(cmpA), .compareValueB(cmpB),
		.outputActionFieldA(actA), .outputActionFieldB(actB), .forceCompareStrobeA(pls[3]),
		.forceCompareStrobeB(pls[4]), .flagClrA(pls[5]), .flagClrB(pls[6]), .flagClrOvf(pls[7]),
		.intEnA(intEn[0]), .intEnB(intEn[1]), .intEnOvf(intEn[2]), .intAckA(pls[8]), .intAckB(pls[9]),
		.intAckOvf(pls[10]), .compareFlagA(flg[0]), .compareFlagB(flg[1]), .overflowFlag(flg[2]),
		.intReqA(irq[0]), .intReqB(irq[1]), .intReqOvf(irq[2]), .outputStateA(st[0]),
		.outputStateB(st[1]), .portDataA(pData[0]), .portDataB(pData[1]), .portDirA(pDir[0]),
		.portDirB(pDir[1]), .pinOutA(pOut[0]), .pinOutB(pOut[1]), .pinOeA(pOe[0]), .pinOeB(pOe[1]));
	toc_pin_model u_pin (.pinOut(pOut[0]), .pinOe(pOe[0]), .pinLevel(lvlA));
	////////////////////
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp8
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc
	task automatic strobe(input int b, input logic [7:0] d);
		wrD = d;
		pls[b] = 1'b1;
		cyc(1);
		pls[b] = 1'b0;
		cyc(1);
	endtask : strobe
	task automatic complete_run;
		if (n_mismatch == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : complete_run
	task automatic wait_flag(input int b);
		int i;
		for (i = 0; i < 600 && flg[b] !== 1'b1; i++) cyc(1);
		if (i == 600) begin
			n_mismatch++;
			complete_run();
		end
	endtask : wait_flag
	////////////////////
	initial begin
		rnd = 8'h4F;
		cyc(20);
		rst = 1'b0;
		cyc(1);
		cmp8({3'h0, st, flg}, 8'h00);
		clkSel = 3'h1;
		cyc(3);
		strobe(0, 8'hFD);
		cmp8(cnt, 8'hFD);
		wait_flag(2);
		cmp8(cnt, 8'h00);
		intEn = 3'h7;
		cyc(3);
		cmp8(8'(irq[2]), 8'h01);
		strobe(10, 8'h00);
		cyc(1);
		cmp8(8'({irq[2], flg[2]}), 8'h00);
		strobe(5, 8'h00);
		strobe(6, 8'h00);
		cmp8(8'(flg[1:0]), 8'h00);
		for (int c = 0; c < 2; c++) begin
			clkSel = 3'h0;
			rnd = lfsr(rnd);
			v = rnd | 8'h10;
			strobe(1 + c, v);
			cmp8(c ? cmpB : cmpA, v);
			strobe(0, 8'h00);
			strobe(5 + c, 8'h00);
			clkSel = 3'h1;
			wait_flag(c);
			cmp8(cnt, v + 8'h02);
			cyc(1);
			cmp8(8'(irq[c]), 8'h01);
			strobe(8 + c, 8'h00);
			cyc(1);
			cmp8(8'({irq[c], flg[c]}), 8'h00);
		end
		clkSel = 3'h0;
		strobe(1, 8'h40);
		// counter written equal to compare: the match is lost
		strobe(0, 8'h40);
		strobe(5, 8'h00);
		clkSel = 3'h1;
		cyc(8);
		cmp8(8'(flg[0]), 8'h00);
		clkSel = 3'h0;
		e = 1'b0;
		for (int k = 0; k < 5; k++) begin
			actA = acts[k];
			rnd = lfsr(rnd);
			pData = rnd[1:0];
			strobe(3, 8'h00);
			case (actA)
				toc_pkg::ACT_SET: e = 1'b1;
				toc_pkg::ACT_CLEAR: e = 1'b0;
				toc_pkg::ACT_TOGGLE: e = ~e;
				default: e = e;
			endcase
			cmp8(8'({st[0], flg[0]}), 8'({e, 1'b0}));
			// state is set up before the pad is driven
			pDir[0] = 1'b1;
			cyc(3);
			cmp8(8'(lvlA), 8'(actA != 2'h0 ? e : pData[0]));
		end
		actB = toc_pkg::ACT_SET;
		strobe(4, 8'h00);
		cmp8(8'(st[1]), 8'h01);
		pData[1] = 1'b0;
		pDir[1] = 1'b1;
		cyc(3);
		cmp8(8'({pOe[1], pOut[1]}), 8'h03);
		modeSel = toc_pkg::WGM_FAST_MAX;
		actA = toc_pkg::ACT_SET;
		strobe(3, 8'h00);
		cmp8(8'(st), 8'h02);
		strobe(1, 8'h5A);
		cmp8(cmpA, 8'h5A);
		pData[0] = 1'b1;
		cyc(2);
		cmp8(8'(pOut[0]), 8'h00);
		// buffered value must reach the comparator at bottom, before the old 0x40 can match
		clkSel = 3'h1;
		wait_flag(0);
		cmp8(cnt, 8'h5C);
		clkSel = 3'h2;
		cyc(1);
		v = cnt;
		cyc(64);
		cmp8(cnt, v + 8'h08);
		complete_run();
	end
endmodule : testbench
